// ===== bench/ddc_device_fsm_bench.sv
// Self-checking bench of the drive device control.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

module ddc_device_fsm_bench;
	import ddc_pkg::*;
	logic clk, rstn, cw_valid, obj_req, obj_wr, obj_ack, obj_err;
	logic sto_standstill, power_stage_enable_input, init_done, fault_event;
	logic stop_done, reaction_done, smoothing_cfg, cyclic_bus_sel;
	logic drive_enable, brake_engage, selftest_run, motion_allowed, ramp_run, ramp_smooth;
	logic [15:0] cw_data, obj_index, obj_wdata, obj_rdata, status_word, op_mode;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;

	ddc_device_fsm u_dut (.*);
	ddc_master u_mst (.*);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard, well above the roughly 120 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// Word stored on one edge, state on the next
	task automatic step(input logic [15:0] w, input logic [15:0] e);
		u_mst.send_cw(w);
		@(negedge clk);
		chk("status", status_word, e);
	endtask

	task automatic wr(input logic [15:0] i, input logic [15:0] d, input logic e);
		logic er;
		logic [15:0] r;
		u_mst.obj(1'b1, i, d, er, r);
		chk("obj_err", {15'h0, er}, {15'h0, e});
	endtask

	task automatic up();
		step(16'h0006, 16'h0021);
		step(16'h0007, 16'h0033);
		step(16'h000F, 16'h0037);
	endtask

	task automatic t_reset();
		logic er;
		logic [15:0] r;
		logic [15:0] rc [5] = '{16'h0002, 16'h0000, 16'h0001, 16'h0001, 16'h0002};
		chk("status", status_word, 16'h0020);
		chk("nr", {13'h0, selftest_run, brake_engage, drive_enable}, 16'h0006);
		for (int k = 0; k < 5; k++) begin
			u_mst.obj(1'b0, 16'h605A + 16'(k), 16'h0000, er, r);
			chk("code", r, rc[k]);
		end
		init_done = 1'b1;
		repeat (6) @(negedge clk);
		chk("status", status_word, 16'h0060);
	endtask

	task automatic t_power();
		up();
		chk("motion", {15'h0, motion_allowed}, 16'h0001);
		step(16'h0000, 16'h0037);
		step(16'h008F, 16'h0037);
		step(16'h000F, 16'h0037);
		step(16'h0007, 16'h0033);
		step(16'h0005, 16'h0060);
	endtask

	// Stop ramp to lockout with code 2, then held quick stop with code 5
	task automatic t_qstop();
		up();
		step(16'h000B, 16'h0017);
		chk("smooth", {15'h0, ramp_smooth}, 16'h0001);
		stop_done = 1'b1;
		repeat (2) @(negedge clk);
		chk("status", status_word, 16'h0060);
		stop_done = 1'b0;
		wr(16'h605A, 16'h0005, 1'b0);
		up();
		step(16'h000B, 16'h0017);
		stop_done = 1'b1;
		repeat (2) @(negedge clk);
		chk("status", status_word, 16'h0017);
		step(16'h000F, 16'h0037);
		stop_done = 1'b0;
		wr(16'h605A, 16'h0009, 1'b1);
		wr(16'h605B, 16'hFFFF, 1'b0);
		wr(16'h605C, 16'h0002, 1'b1);
	endtask

	task automatic t_fault();
		fault_event = 1'b1;
		@(negedge clk);
		fault_event = 1'b0;
		chk("status", status_word, 16'h003F);
		chk("drive", {15'h0, drive_enable}, 16'h0001);
		chk("ramp", {15'h0, ramp_run}, 16'h0001);
		reaction_done = 1'b1;
		repeat (2) @(negedge clk);
		reaction_done = 1'b0;
		chk("status", status_word, 16'h0028);
		step(16'h0000, 16'h0028);
		step(16'h0080, 16'h0060);
	endtask

	task automatic t_pins_mode();
		up();
		power_stage_enable_input = 1'b0;
		repeat (6) @(negedge clk);
		chk("status", status_word, 16'h0060);
		power_stage_enable_input = 1'b1;
		wr(16'h6060, 16'h0008, 1'b1);
		cyclic_bus_sel = 1'b1;
		wr(16'h6060, 16'h0008, 1'b0);
		chk("mode", op_mode, 16'h0008);
		wr(16'h6041, 16'h0000, 1'b1);
		wr(16'h6040, 16'h0006, 1'b0);
		@(negedge clk);
		chk("status", status_word, 16'h0021);
		sto_standstill = 1'b1;
		repeat (6) @(negedge clk);
		chk("status", status_word, 16'h0060);
		sto_standstill = 1'b0;
	endtask

	initial begin
		rstn = 1'b0;
		sto_standstill = 1'b0;
		power_stage_enable_input = 1'b1;
		init_done = 1'b0;
		fault_event = 1'b0;
		stop_done = 1'b0;
		reaction_done = 1'b0;
		smoothing_cfg = 1'b1;
		cyclic_bus_sel = 1'b0;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_power();
		t_qstop();
		t_fault();
		t_pins_mode();
		give_verdict();
	end
endmodule

`default_nettype wire

// ===== bench/ddc_device_fsm_chk.sv
// Port checker of the drive device control.
// Assumes it is bound into ddc_device_fsm.
`timescale 1ns/100ps
`default_nettype none

module ddc_chk
	import ddc_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        cw_valid,
	input wire logic [15:0] cw_data,
	input wire logic        obj_req,
	input wire logic        obj_wr,
	input wire logic [15:0] obj_index,
	input wire logic [15:0] obj_wdata,
	input wire logic        obj_ack,
	input wire logic        fault_event,
	input wire logic        reaction_done,
	input wire logic [15:0] status_word,
	input wire logic        drive_enable,
	input wire logic        brake_engage,
	input wire logic        selftest_run,
	input wire logic        motion_allowed,
	input wire logic        ramp_smooth
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	logic held_b7;  // Bit 7 of the stored command word, tracked from the ports

	// Same store priority as the device: process data before an object write
	always_ff @(posedge clk) begin
		if (!rstn) begin
			held_b7 <= 1'b0;
		end else if (cw_valid) begin
			held_b7 <= cw_data[CW_FAULT_RST];
		end else if (obj_req && obj_wr && obj_index == OBJ_CMD_WORD) begin
			held_b7 <= obj_wdata[CW_FAULT_RST];
		end
	end

	// A 0 to 1 step of bit 7 being stored while faulted
	sequence s_b7;
		status_word == 16'h0028 && !held_b7 && cw_valid && cw_data[CW_FAULT_RST];
	endsequence

	property p_ack; obj_req |=> obj_ack; endproperty
	a_ack: assert property (p_ack) else $error("object ack missing");
	property p_fre; fault_event && !status_word[3] |=> status_word == 16'h003F; endproperty
	a_fre: assert property (p_fre) else $error("fault not taken");
	property p_frx; status_word == 16'h003F && reaction_done |=> status_word == 16'h0028;
	endproperty
	a_frx: assert property (p_frx) else $error("fault state missed");
	property p_frd; status_word == 16'h003F |-> drive_enable && !brake_engage; endproperty
	a_frd: assert property (p_frd) else $error("drive off in reaction");
	property p_nr; status_word == 16'h0020 |-> selftest_run && brake_engage && !drive_enable;
	endproperty
	a_nr: assert property (p_nr) else $error("not ready outputs");
	property p_mot; motion_allowed == (status_word == 16'h0037); endproperty
	a_mot: assert property (p_mot) else $error("motion gate wrong");
	property p_smo; ramp_smooth |-> status_word == 16'h0017; endproperty
	a_smo: assert property (p_smo) else $error("smoothing outside quick stop");
	property p_frst; s_b7 |-> ##2 status_word == 16'h0060; endproperty
	a_frst: assert property (p_frst) else $error("fault reset ignored");
endmodule

bind ddc_device_fsm ddc_chk u_chk (.*);

`default_nettype wire

// ===== bench/ddc_master.sv
// Fieldbus master model: sends command words and object requests.
// Assumes the device samples on the rising edge of clk.
`timescale 1ns/100ps
`default_nettype none

module ddc_master (
	// Clock
	input wire logic        clk,
	// Command word
	output logic            cw_valid,
	output logic [15:0]     cw_data,
	// Object access
	output logic            obj_req,
	output logic            obj_wr,
	output logic [15:0]     obj_index,
	output logic [15:0]     obj_wdata,
	input wire logic        obj_ack,
	input wire logic        obj_err,
	input wire logic [15:0] obj_rdata
);
	// Idle bus at time zero
	initial begin
		cw_valid = 1'b0;
		cw_data = 16'h0000;
		obj_req = 1'b0;
		obj_wr = 1'b0;
		obj_index = 16'h0000;
		obj_wdata = 16'h0000;
	end

	// One word for one edge; a full cycle passes before the next one
	task automatic send_cw(input logic [15:0] w);
		@(negedge clk);
		cw_valid = 1'b1;
		cw_data = w;
		@(negedge clk);
		cw_valid = 1'b0;
	endtask

	// One-cycle request, then a bounded wait for the acknowledge
	task automatic obj(input logic wr, input logic [15:0] idx,
		input logic [15:0] d, output logic err, output logic [15:0] rd);
		@(negedge clk);
		obj_req = 1'b1;
		obj_wr = wr;
		obj_index = idx;
		obj_wdata = d;
		@(negedge clk);
		obj_req = 1'b0;
		for (int i = 0; i < 3 && obj_ack !== 1'b1; i++) @(negedge clk);
		err = obj_err;
		rd = obj_rdata;
		// A missing answer reads as unknown, so the bench counts a mismatch
		if (obj_ack !== 1'b1) begin
			err = 1'bx;
			rd = 16'hXXXX;
		end
	endtask
endmodule

`default_nettype wire

// ===== hdl/ddc_cmd_decode.sv
// Command word decoder: turns the held word into command flags.
// Assumes the word only changes on a clock edge of the same domain.
`timescale 1ns/100ps
`default_nettype none

module ddc_cmd_decode
	import ddc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Decoded commands
	ddc_cmd_if.dec   cmd
);

	logic prev_fr;  // Bit 7 as seen one cycle earlier

	//------------------------------------------------------------
	// Edge memory for the fault reset bit
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prev_fr <= 1'b0;
		end else begin
			prev_fr <= cmd.cw[CW_FAULT_RST];
		end
	end

	//------------------------------------------------------------
	// Level decode; bit 7 high masks every other command
	//------------------------------------------------------------
	always_comb begin
		cmd.shutdown   = 1'b0;
		cmd.switch_on  = 1'b0;
		cmd.dis_volt   = 1'b0;
		cmd.quick_stop = 1'b0;
		cmd.dis_op     = 1'b0;
		cmd.en_op      = 1'b0;
		if (!cmd.cw[CW_FAULT_RST]) begin
			// Bit 3 is ignored for shutdown and switch-on
			cmd.shutdown   = (cmd.cw[2:0] == 3'h6);
			cmd.switch_on  = (cmd.cw[2:0] == 3'h7);
			cmd.dis_volt   = !cmd.cw[CW_VOLTAGE] && cmd.cw[CW_SWITCH_ON];
			cmd.quick_stop = !cmd.cw[CW_QSTOP_N] && cmd.cw[CW_VOLTAGE];
			cmd.dis_op     = (cmd.cw[3:0] == 4'h7);
			cmd.en_op      = (cmd.cw[3:0] == 4'hF);
		end
		// Only the 0 to 1 step counts, other bits ignored
		cmd.fault_rst = cmd.cw[CW_FAULT_RST] && !prev_fr;
	end

endmodule

`default_nettype wire

// ===== hdl/ddc_cmd_if.sv
// Command word and its decoded commands between the decoder and the state machine.
// Assumes both ends run on the same control clock.
`timescale 1ns/100ps
`default_nettype none

interface ddc_cmd_if;
	logic [15:0] cw;          // Held command word
	logic        shutdown;    // Shutdown pattern present
	logic        switch_on;   // Switch-on pattern present
	logic        dis_volt;    // Disable-voltage pattern present
	logic        quick_stop;  // Quick-stop pattern present
	logic        dis_op;      // Disable-operation pattern present
	logic        en_op;       // Enable-operation pattern present
	logic        fault_rst;   // One-cycle pulse on a rising bit 7

	modport dec (input cw, output shutdown, switch_on, dis_volt, quick_stop,
		dis_op, en_op, fault_rst);
	modport fsm (output cw, input shutdown, switch_on, dis_volt, quick_stop,
		dis_op, en_op, fault_rst);
endinterface

`default_nettype wire

// ===== hdl/ddc_device_fsm.sv
// Drive device control: power state machine, state report word,
// option code objects and operation mode selector.
// Assumes object requests and internal events come from logic on clk,
// and that the torque-off and stage-enable levels arrive from pins.
`timescale 1ns/100ps
`default_nettype none

module ddc_device_fsm
	import ddc_pkg::*;
(
	// Clock and reset
	input wire logic         clk,
	input wire logic         rstn,
	// Cyclic command word from process data
	input wire logic         cw_valid,
	input wire logic [15:0]  cw_data,
	// Object access from service data
	input wire logic         obj_req,
	input wire logic         obj_wr,
	input wire logic [15:0]  obj_index,
	input wire logic [15:0]  obj_wdata,
	output logic             obj_ack,
	output logic             obj_err,
	output logic [15:0]      obj_rdata,
	// Safety pins
	input wire logic         sto_standstill,
	input wire logic         power_stage_enable_input,
	// Internal events
	input wire logic         init_done,
	input wire logic         fault_event,
	input wire logic         stop_done,
	input wire logic         reaction_done,
	input wire logic         smoothing_cfg,
	input wire logic         cyclic_bus_sel,
	// Drive status and control
	output logic [15:0]      status_word,
	output logic             drive_enable,
	output logic             brake_engage,
	output logic             selftest_run,
	output logic             motion_allowed,
	output logic             ramp_run,
	output logic             ramp_smooth,
	output logic [15:0]      op_mode
);

	//------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------
	ddc_cmd_if   cmd ();           // Decoder link
	ddc_state_t  state;            // Current power state
	ddc_state_t  next_state;       // Power state for the next edge
	logic [15:0] cmd_word;         // Held command word
	logic [15:0] qs_code;          // Quick stop option code
	logic [15:0] shut_code;        // Shutdown option code
	logic [15:0] disop_code;       // Disable operation option code
	logic [15:0] halt_code;        // Halt option code
	logic [15:0] fault_code;       // Fault reaction option code
	logic [2:0]  sto_sync;         // Torque-off synchroniser
	logic [2:0]  enp_sync;         // Stage enable synchroniser
	logic        sto_level;        // Filtered torque-off level
	logic        enp_level;        // Filtered stage enable level
	logic        power_ok;         // Stage may be energised
	logic        qs_hold;          // Stay in quick stop after stopping
	logic        wr_ok;            // Object write acceptable
	logic [15:0] rd_val;           // Object read value

	//------------------------------------------------------------
	// Helper functions
	//------------------------------------------------------------
	// Signed range test, used for every option code and the hold band
	function automatic logic in_range(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
	endfunction

	// State to report pattern; don't-care bit 5 reads as one
	function automatic logic [15:0] report(input ddc_state_t s);
		logic [15:0] w;
		w = 16'h0000;
		w[SW_QSTOP_N] = 1'b1;
		unique case (s)
			ST_NOT_READY: begin
				w[SW_LOCKOUT] = 1'b0;
			end
			ST_SW_ON_DIS: begin
				w[SW_LOCKOUT] = 1'b1;
			end
			ST_READY: begin
				w[SW_READY] = 1'b1;
			end
			ST_SWITCHED_ON: begin
				w[1:0] = 2'h3;
				w[SW_VOLTAGE] = 1'b1;
			end
			ST_OP_ENABLED: begin
				w[2:0] = 3'h7;
				w[SW_VOLTAGE] = 1'b1;
			end
			ST_QSTOP: begin
				w[2:0] = 3'h7;
				w[SW_QSTOP_N] = 1'b0;
				w[SW_VOLTAGE] = 1'b1;
			end
			ST_FAULT_REACT: begin
				w[3:0] = 4'hF;
				w[SW_VOLTAGE] = 1'b1;
			end
			ST_FAULT: begin
				w[3:0] = 4'h8;
			end
		endcase
		report = w;
	endfunction

	//------------------------------------------------------------
	// Command decoder
	//------------------------------------------------------------
	assign cmd.cw = cmd_word;

	ddc_cmd_decode u_decode (
		.clk  (clk),
		.rstn (rstn),
		.cmd  (cmd.dec)
	);

	//------------------------------------------------------------
	// Pin synchronisers: three flops, change taken when the
	// second and third agree, so a single-cycle glitch is dropped
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sto_sync  <= 3'h7;
			enp_sync  <= 3'h0;
			sto_level <= 1'b1;
			enp_level <= 1'b0;
		end else begin
			sto_sync <= {sto_sync[1:0], sto_standstill};
			enp_sync <= {enp_sync[1:0], power_stage_enable_input};
			if (sto_sync[1] == sto_sync[2]) begin
				sto_level <= sto_sync[2];
			end
			if (enp_sync[1] == enp_sync[2]) begin
				enp_level <= enp_sync[2];
			end
		end
	end

	// Reset assumes the unsafe case until the pins say otherwise
	assign power_ok = !sto_level && enp_level;
	// Codes 6 to 8 also hold in quick stop, as code 5 does
	assign qs_hold  = in_range(qs_code, QS_HOLD_MIN, QS_HOLD_MAX);

	//------------------------------------------------------------
	// Command word register; process data wins over an object
	// write in the same cycle. It is the only control source.
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmd_word <= RST_CMD_WORD;
		end else if (cw_valid) begin
			cmd_word <= cw_data;
		end else if (obj_req && obj_wr && obj_index == OBJ_CMD_WORD) begin
			cmd_word <= obj_wdata;
		end
	end

	//------------------------------------------------------------
	// Next state: faults first, then power loss, then commands.
	// Any pattern with no meaning in a state keeps the state.
	//------------------------------------------------------------
	always_comb begin
		next_state = state;
		if (fault_event && state != ST_FAULT && state != ST_FAULT_REACT) begin
			next_state = ST_FAULT_REACT;
		end else begin
			unique case (state)
				ST_NOT_READY: begin
					// Leaves when self-test ends, or on a fault event
					if (init_done) begin
						next_state = ST_SW_ON_DIS;
					end
				end
				ST_SW_ON_DIS: begin
					// Held here while the stage is not allowed on
					if (cmd.shutdown && power_ok) begin
						next_state = ST_READY;
					end
				end
				ST_READY: begin
					if (!power_ok || cmd.dis_volt || cmd.quick_stop) begin
						next_state = ST_SW_ON_DIS;
					end else if (cmd.switch_on) begin
						next_state = ST_SWITCHED_ON;
					end
				end
				ST_SWITCHED_ON: begin
					if (!power_ok || cmd.dis_volt || cmd.quick_stop) begin
						next_state = ST_SW_ON_DIS;
					end else if (cmd.shutdown) begin
						next_state = ST_READY;
					end else if (cmd.en_op) begin
						next_state = ST_OP_ENABLED;
					end
				end
				ST_OP_ENABLED: begin
					if (!power_ok || cmd.dis_volt) begin
						next_state = ST_SW_ON_DIS;
					end else if (cmd.quick_stop) begin
						next_state = ST_QSTOP;
					end else if (cmd.shutdown) begin
						next_state = ST_READY;
					end else if (cmd.dis_op) begin
						next_state = ST_SWITCHED_ON;
					end
				end
				ST_QSTOP: begin
					if (!power_ok || cmd.dis_volt) begin
						next_state = ST_SW_ON_DIS;
					end else if (qs_hold && cmd.en_op) begin
						next_state = ST_OP_ENABLED;
					end else if (stop_done && !qs_hold) begin
						next_state = ST_SW_ON_DIS;
					end
				end
				ST_FAULT_REACT: begin
					// Stop runs with the drive on, then fault
					if (reaction_done) begin
						next_state = ST_FAULT;
					end
				end
				ST_FAULT: begin
					if (cmd.fault_rst) begin
						next_state = ST_SW_ON_DIS;
					end
				end
			endcase
		end
	end

	//------------------------------------------------------------
	// State register
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= ST_NOT_READY;
		end else begin
			state <= next_state;
		end
	end

	//------------------------------------------------------------
	// Drive outputs, registered from the next state so that they
	// change on the same edge as the state itself
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			status_word    <= 16'h0020;
			drive_enable   <= 1'b0;
			brake_engage   <= 1'b1;
			selftest_run   <= 1'b1;
			motion_allowed <= 1'b0;
			ramp_run       <= 1'b0;
			ramp_smooth    <= 1'b0;
		end else begin
			status_word    <= report(next_state);
			// Drive on only in enabled, quick stop and fault reaction
			drive_enable   <= next_state inside {ST_OP_ENABLED, ST_QSTOP,
				ST_FAULT_REACT};
			// Brake held whenever the drive function is off
			brake_engage   <= !(next_state inside {ST_OP_ENABLED, ST_QSTOP,
				ST_FAULT_REACT});
			selftest_run   <= (next_state == ST_NOT_READY);
			motion_allowed <= (next_state == ST_OP_ENABLED);
			ramp_run       <= next_state inside {ST_QSTOP, ST_FAULT_REACT};
			// Error stop never smoothed, quick stop follows profile
			ramp_smooth    <= (next_state == ST_QSTOP) && smoothing_cfg;
		end
	end

	//------------------------------------------------------------
	// Object write check: range per code, mode per bus kind,
	// report word read-only, unknown index refused
	//------------------------------------------------------------
	always_comb begin
		unique case (obj_index)
			OBJ_QS_CODE:    wr_ok = in_range(obj_wdata, QS_MIN, QS_MAX);
			OBJ_SHUT_CODE:  wr_ok = in_range(obj_wdata, SHUT_MIN, SHUT_MAX);
			OBJ_DISOP_CODE: wr_ok = in_range(obj_wdata, DISOP_MIN, DISOP_MAX);
			OBJ_HALT_CODE:  wr_ok = in_range(obj_wdata, HALT_MIN, HALT_MAX);
			OBJ_FAULT_CODE: wr_ok = in_range(obj_wdata, FAULT_MIN, FAULT_MAX);
			OBJ_CMD_WORD:   wr_ok = 1'b1;
			OBJ_OP_MODE:    wr_ok = (obj_wdata inside {MODE_PP, MODE_PV, MODE_HM,
				MODE_IP}) || (cyclic_bus_sel && (obj_wdata inside {MODE_CSP,
				MODE_CSV, MODE_CST}));
			default:        wr_ok = 1'b0;
		endcase
	end

	// Read mux; the report word shows the live state
	always_comb begin
		unique case (obj_index)
			OBJ_QS_CODE:    rd_val = qs_code;
			OBJ_SHUT_CODE:  rd_val = shut_code;
			OBJ_DISOP_CODE: rd_val = disop_code;
			OBJ_HALT_CODE:  rd_val = halt_code;
			OBJ_FAULT_CODE: rd_val = fault_code;
			OBJ_CMD_WORD:   rd_val = cmd_word;
			OBJ_STAT_WORD:  rd_val = status_word;
			OBJ_OP_MODE:    rd_val = op_mode;
			default:        rd_val = 16'h0000;
		endcase
	end

	//------------------------------------------------------------
	// Option code and mode storage; refused writes leave the
	// old value so a bad code never reaches the stop logic
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			qs_code    <= RST_QS_CODE;
			shut_code  <= RST_SHUT_CODE;
			disop_code <= RST_DISOP_CODE;
			halt_code  <= RST_HALT_CODE;
			fault_code <= RST_FAULT_CODE;
			op_mode    <= RST_OP_MODE;
		end else if (obj_req && obj_wr && wr_ok) begin
			unique case (obj_index)
				OBJ_QS_CODE:    qs_code    <= obj_wdata;
				OBJ_SHUT_CODE:  shut_code  <= obj_wdata;
				OBJ_DISOP_CODE: disop_code <= obj_wdata;
				OBJ_HALT_CODE:  halt_code  <= obj_wdata;
				OBJ_FAULT_CODE: fault_code <= obj_wdata;
				OBJ_OP_MODE:    op_mode    <= obj_wdata;
				default: begin
					// Command word is stored in its own process
				end
			endcase
		end
	end

	//------------------------------------------------------------
	// Object answer, one cycle after the request
	//------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			obj_ack   <= 1'b0;
			obj_err   <= 1'b0;
			obj_rdata <= 16'h0000;
		end else begin
			obj_ack <= obj_req;
			obj_err <= obj_req && (obj_wr ? !wr_ok : (rd_val == 16'h0000 &&
				!(obj_index inside {OBJ_QS_CODE, OBJ_SHUT_CODE, OBJ_DISOP_CODE,
				OBJ_HALT_CODE, OBJ_FAULT_CODE, OBJ_CMD_WORD, OBJ_STAT_WORD,
				OBJ_OP_MODE})));
			if (obj_req && !obj_wr) begin
				obj_rdata <= rd_val;
			end
		end
	end

endmodule

`default_nettype wire

// ===== hdl/ddc_pkg.sv
// Constants, state encoding and object indices of the drive device control.
// Assumes a single 40 MHz control clock and a synchronous active-low reset.
//
// Summary of operation
// - Commands and internal faults both move the state
// - Shutdown 110, switch-on 111, disable-voltage x0 1
// - Quick stop x01x; operation 0111 off, 1111 on
// - Rising bit 7 leaves fault for switch-on-disabled
// - Status 0000 low nibble; bit 6 marks lockout
// - Ready, on, enabled, quick stop status patterns
// - Fault 1000, fault reaction 1111, bit 6 low
// - Motion commands only while operation is enabled
// - Not ready: self-test, brake engaged, drive off
// - Torque off or stage disable forces lockout state, except in not ready, fault reaction and fault
// - Quick stop code 5 holds; enable resumes operation
// - Quick-stop ramp smoothed, error-stop ramp never
// - Modes 1,3,6,7 always; 8-10 cyclic bus only
// - No remote signal; control word is sole source
// - Fault reaction stops with drive on, then faults

package ddc_pkg;

	//------------------------------------------------------------
	// Object indices
	//------------------------------------------------------------
	localparam logic [15:0] OBJ_QS_CODE    = 16'h605A;
	localparam logic [15:0] OBJ_SHUT_CODE  = 16'h605B;
	localparam logic [15:0] OBJ_DISOP_CODE = 16'h605C;
	localparam logic [15:0] OBJ_HALT_CODE  = 16'h605D;
	localparam logic [15:0] OBJ_FAULT_CODE = 16'h605E;
	localparam logic [15:0] OBJ_CMD_WORD   = 16'h6040;
	localparam logic [15:0] OBJ_STAT_WORD  = 16'h6041;
	localparam logic [15:0] OBJ_OP_MODE    = 16'h6060;

	//------------------------------------------------------------
	// Option code reset values and supported ranges (signed)
	//------------------------------------------------------------
	localparam logic [15:0] RST_QS_CODE    = 16'h0002;
	localparam logic [15:0] RST_SHUT_CODE  = 16'h0000;
	localparam logic [15:0] RST_DISOP_CODE = 16'h0001;
	localparam logic [15:0] RST_HALT_CODE  = 16'h0001;
	localparam logic [15:0] RST_FAULT_CODE = 16'h0002;
	localparam logic [15:0] RST_OP_MODE    = 16'h0001;
	localparam logic [15:0] RST_CMD_WORD   = 16'h0000;
	localparam logic [15:0] QS_MIN         = 16'h0000;
	localparam logic [15:0] QS_MAX         = 16'h0008;
	localparam logic [15:0] SHUT_MIN       = 16'hFFFF;
	localparam logic [15:0] SHUT_MAX       = 16'h0001;
	localparam logic [15:0] DISOP_MIN      = 16'h0000;
	localparam logic [15:0] DISOP_MAX      = 16'h0001;
	localparam logic [15:0] HALT_MIN       = 16'h0000;
	localparam logic [15:0] HALT_MAX       = 16'h0004;
	localparam logic [15:0] FAULT_MIN      = 16'h0000;
	localparam logic [15:0] FAULT_MAX      = 16'h0004;
	localparam logic [15:0] QS_HOLD_MIN    = 16'h0005;
	localparam logic [15:0] QS_HOLD_MAX    = 16'h0008;

	//------------------------------------------------------------
	// Operation mode codes
	//------------------------------------------------------------
	localparam logic [15:0] MODE_PP  = 16'h0001;
	localparam logic [15:0] MODE_PV  = 16'h0003;
	localparam logic [15:0] MODE_HM  = 16'h0006;
	localparam logic [15:0] MODE_IP  = 16'h0007;
	localparam logic [15:0] MODE_CSP = 16'h0008;
	localparam logic [15:0] MODE_CSV = 16'h0009;
	localparam logic [15:0] MODE_CST = 16'h000A;

	//------------------------------------------------------------
	// Command word bit positions
	//------------------------------------------------------------
	localparam int CW_SWITCH_ON = 0;
	localparam int CW_VOLTAGE   = 1;
	localparam int CW_QSTOP_N   = 2;
	localparam int CW_ENABLE_OP = 3;
	localparam int CW_FAULT_RST = 7;

	//------------------------------------------------------------
	// State report word bit positions
	//------------------------------------------------------------
	localparam int SW_READY     = 0;
	localparam int SW_ON        = 1;
	localparam int SW_OP_EN     = 2;
	localparam int SW_FAULT     = 3;
	localparam int SW_VOLTAGE   = 4;
	localparam int SW_QSTOP_N   = 5;
	localparam int SW_LOCKOUT   = 6;

	//------------------------------------------------------------
	// Power states, Gray coded along the usual path
	//------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_NOT_READY   = 3'h0,
		ST_SW_ON_DIS   = 3'h1,
		ST_READY       = 3'h3,
		ST_SWITCHED_ON = 3'h2,
		ST_OP_ENABLED  = 3'h6,
		ST_QSTOP       = 3'h7,
		ST_FAULT_REACT = 3'h5,
		ST_FAULT       = 3'h4
	} ddc_state_t;

endpackage
